// ### pkg/lfpit_if.sv
// Link between the timer control logic and its binary counter.
interface lfpit_if;

    logic                 run;
    logic                 tick;
    lfpit_pkg::sel_t      sel;
    logic                 wrap;
    lfpit_pkg::count_t    count;

    modport ctrl (output run, tick, sel, input wrap, count);
    modport cnt  (input run, tick, sel, output wrap, count);

endinterface

// ### pkg/lfpit_map.svh
// Register offsets, field positions, reset values and widths of the interval timer.
`ifndef LFPIT_MAP_SVH
`define LFPIT_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define LFPIT_IDX_POWER   12'hf76
`define LFPIT_IDX_CTRL    12'hfc8
`define LFPIT_IDX_STAT    12'hfd0
`define LFPIT_IDX_CLR     12'hfd1
`define LFPIT_IDX_IEN     12'hfd2
`define LFPIT_IDX_CNT     12'hfd3

// Bus widths.
`define LFPIT_ADDR_W      14
`define LFPIT_DATA_W      32
`define LFPIT_BE_W        4

// Field positions.
`define LFPIT_SUPPLY_BIT  5
`define LFPIT_RUN_BIT     0
`define LFPIT_SEL_LSB     1
`define LFPIT_SEL_MSB     3
`define LFPIT_EVT_BIT     0

// Reset values.
`define LFPIT_POWER_RST   8'h00
`define LFPIT_SEL_RST     3'h0

// Counter width and the interval exponent selected by code zero.
`define LFPIT_CNT_W       15
`define LFPIT_EXP_MAX     4'hf

`endif

// ### pkg/lfpit_pkg.sv
// Types shared by the interval timer modules.
`include "lfpit_map.svh"

package lfpit_pkg;

    typedef logic [`LFPIT_SEL_MSB-`LFPIT_SEL_LSB:0] sel_t;
    typedef logic [`LFPIT_CNT_W-1:0]                count_t;
    typedef logic [7:0]                             byte_t;

    // Register targeted by the current bus address.
    typedef enum logic [2:0] {
        REG_NONE,
        REG_POWER,
        REG_CTRL,
        REG_STAT,
        REG_CLR,
        REG_IEN,
        REG_CNT
    } reg_sel_e;

endpackage

// ### rtl/interval_counter.sv
// Free-running binary counter of low-frequency ticks with interval wrap pulse.
`include "lfpit_map.svh"

module interval_counter (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control side.
    lfpit_if.cnt      bus
);

    //------------------------------------------------------------
    // Interval mask
    //------------------------------------------------------------

    logic [3:0]        expo;
    lfpit_pkg::count_t mask;
    logic              hit;
    lfpit_pkg::count_t count_ff;
    logic              wrap_ff;

    // Code zero selects the longest interval; each step halves it.
    assign expo = `LFPIT_EXP_MAX - {1'b0, bus.sel};
    assign mask = lfpit_pkg::count_t'((16'h0001 << expo) - 16'h0001);
    assign hit  = (count_ff & mask) == mask;

    //------------------------------------------------------------
    // Counter and wrap pulse
    //------------------------------------------------------------

    // The counter is cleared whenever the timer is stopped.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_ff <= '0;
        end else if (!bus.run) begin
            count_ff <= '0;
        end else if (bus.tick) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    // The selected bit wraps on the tick that finds the low bits all ones.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wrap_ff <= 1'b0;
        end else begin
            wrap_ff <= bus.run && bus.tick && hit;
        end
    end

    assign bus.count = count_ff;
    assign bus.wrap  = wrap_ff;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------

    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    count_adv_a: assert property (bus.run && bus.tick |=> count_ff == $past(count_ff) + 1'b1)
        else $error("Counter did not advance on a tick.");
    stop_zero_a: assert property (!bus.run |=> count_ff == '0)
        else $error("Counter not cleared while stopped.");
    wrap_cause_a: assert property (wrap_ff |-> $past(bus.run && bus.tick && hit))
        else $error("Wrap pulse without an interval wrap.");
    wrap_pulse_a: assert property (wrap_ff |=> !wrap_ff)
        else $error("Wrap pulse longer than one cycle.");
    wrap_bound_a: assert property (wrap_ff |-> count_ff[7:0] == 8'h00)
        else $error("Wrap pulse off an interval boundary.");

endmodule

// ### rtl/low_freq_periodic_interval_timer.sv
// Periodic interval timer on the low-frequency clock with Avalon-MM registers.
`include "lfpit_map.svh"

module low_freq_periodic_interval_timer (
    // Clock and reset.
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Avalon-MM slave.
    input  wire logic [`LFPIT_ADDR_W-1:0]    avs_address_i,
    input  wire logic                        avs_read_i,
    input  wire logic                        avs_write_i,
    input  wire logic [`LFPIT_DATA_W-1:0]    avs_writedata_i,
    input  wire logic [`LFPIT_BE_W-1:0]      avs_byteenable_i,
    output logic      [`LFPIT_DATA_W-1:0]    avs_readdata_o,
    output logic                             avs_waitrequest_o,
    // Chip-level clock and mode inputs, asynchronous.
    input  wire logic                        low_frequency_clock_i,
    input  wire logic                        low_freq_osc_enable_i,
    input  wire logic                        stop_mode_i,
    input  wire logic                        deepest_sleep_mode_i,
    // Interrupts.
    output logic                             interval_interrupt_request_o,
    output logic                             irq_o
);

    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------

    lfpit_if bus ();

    lfpit_pkg::reg_sel_e         reg_sel;
    logic                        req;
    logic                        ack_ff;
    logic                        wr_acc;
    logic                        rd_take;
    logic [`LFPIT_DATA_W-1:0]    rdata;
    logic [`LFPIT_DATA_W-1:0]    rdata_ff;
    lfpit_pkg::byte_t            power_ff;
    logic                        supply;
    logic                        run_ff;
    lfpit_pkg::sel_t             sel_ff;
    lfpit_pkg::sel_t             wsel;
    logic                        ctrl_wr;
    logic                        stat_ff;
    logic                        ien_ff;
    logic                        clr;
    logic                        lf_meta_ff;
    logic                        lf_sync_ff;
    logic                        lf_prev_ff;
    logic [2:0]                  mode_meta_ff;
    logic [2:0]                  mode_sync_ff;
    logic                        halt;

    //------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------

    // Only word-aligned byte addresses hit a register.
    always_comb begin
        reg_sel = lfpit_pkg::REG_NONE;
        if (avs_address_i[1:0] == 2'h0) begin
            unique case (avs_address_i[`LFPIT_ADDR_W-1:2])
                `LFPIT_IDX_POWER: reg_sel = lfpit_pkg::REG_POWER;
                `LFPIT_IDX_CTRL:  reg_sel = lfpit_pkg::REG_CTRL;
                `LFPIT_IDX_STAT:  reg_sel = lfpit_pkg::REG_STAT;
                `LFPIT_IDX_CLR:   reg_sel = lfpit_pkg::REG_CLR;
                `LFPIT_IDX_IEN:   reg_sel = lfpit_pkg::REG_IEN;
                `LFPIT_IDX_CNT:   reg_sel = lfpit_pkg::REG_CNT;
                default:          reg_sel = lfpit_pkg::REG_NONE;
            endcase
        end
    end

    //------------------------------------------------------------
    // Bus handshake
    //------------------------------------------------------------

    // Every access takes exactly one wait cycle, which lets read data
    // come from a flop without a combinational path to the bus.
    assign req               = avs_read_i || avs_write_i;
    assign avs_waitrequest_o = req && !ack_ff;
    assign wr_acc            = avs_write_i && ack_ff && avs_byteenable_i[0];
    assign rd_take           = avs_read_i && !ack_ff;

    // The accept flag rises for one cycle per request and then clears.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req && !ack_ff;
        end
    end

    // Read data are captured in the wait cycle and held to the accept edge.
    always_comb begin
        rdata = '0;
        unique case (reg_sel)
            lfpit_pkg::REG_POWER: rdata = `LFPIT_DATA_W'(power_ff);
            lfpit_pkg::REG_CTRL:  rdata = `LFPIT_DATA_W'({sel_ff, run_ff});
            lfpit_pkg::REG_STAT:  rdata = `LFPIT_DATA_W'(stat_ff);
            lfpit_pkg::REG_IEN:   rdata = `LFPIT_DATA_W'(ien_ff);
            lfpit_pkg::REG_CNT:   rdata = `LFPIT_DATA_W'(bus.count);
            lfpit_pkg::REG_CLR:   rdata = '0;
            lfpit_pkg::REG_NONE:  rdata = '0;
        endcase
    end

    // Captured once per read, in the wait cycle, so the value cannot tear.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff <= '0;
        end else if (rd_take) begin
            rdata_ff <= rdata;
        end
    end

    // The port shows the flop only; no register reaches it combinationally.
    assign avs_readdata_o = rdata_ff;

    //------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------

    // The low-frequency clock is sampled as data; a rising edge on the
    // synchronised copy is one counted cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lf_meta_ff <= 1'b0;
            lf_sync_ff <= 1'b0;
            lf_prev_ff <= 1'b0;
        end else begin
            lf_meta_ff <= low_frequency_clock_i;
            lf_sync_ff <= lf_meta_ff;
            lf_prev_ff <= lf_sync_ff;
        end
    end

    // Oscillator enable and the two deep modes.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_meta_ff <= 3'h0;
            mode_sync_ff <= 3'h0;
        end else begin
            mode_meta_ff <= {deepest_sleep_mode_i, stop_mode_i, low_freq_osc_enable_i};
            mode_sync_ff <= mode_meta_ff;
        end
    end

    // Any one of the three stops the timer; they are levels, not edges.
    assign halt = !mode_sync_ff[0] || mode_sync_ff[1] || mode_sync_ff[2];

    //------------------------------------------------------------
    // Power gate register
    //------------------------------------------------------------

    // All eight bits are stored; only the supply bit acts here.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_ff <= `LFPIT_POWER_RST;
        end else if (wr_acc && reg_sel == lfpit_pkg::REG_POWER) begin
            power_ff <= avs_writedata_i[7:0];
        end
    end

    // Without supply the timer sees no ticks and refuses control writes.
    assign supply = power_ff[`LFPIT_SUPPLY_BIT];

    //------------------------------------------------------------
    // Control register
    //------------------------------------------------------------

    // Control writes need the supply bit; the code field sits in bits 3 to 1.
    assign ctrl_wr = wr_acc && reg_sel == lfpit_pkg::REG_CTRL && supply;
    assign wsel    = avs_writedata_i[`LFPIT_SEL_MSB:`LFPIT_SEL_LSB];

    // Losing the oscillator or entering a deep mode wins over a write,
    // so software cannot start a timer that has no clock to count.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_ff <= 1'b0;
        end else if (halt) begin
            run_ff <= 1'b0;
        end else if (ctrl_wr) begin
            run_ff <= avs_writedata_i[`LFPIT_RUN_BIT];
        end
    end

    // The code is writable only while stopped, so a starting write carries
    // a new code and a stopping write cannot; a halt leaves it intact.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_ff <= `LFPIT_SEL_RST;
        end else if (ctrl_wr && !run_ff) begin
            sel_ff <= wsel;
        end
    end

    //------------------------------------------------------------
    // Counter
    //------------------------------------------------------------

    // The counter sees the run bit, the stored code and one tick per slow edge.
    assign bus.run  = run_ff;
    assign bus.sel  = sel_ff;
    assign bus.tick = supply && lf_sync_ff && !lf_prev_ff;

    interval_counter u_counter (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .bus   (bus.cnt)
    );

    //------------------------------------------------------------
    // Interrupt status, clear and enable
    //------------------------------------------------------------

    // Only a one in the event bit clears; a zero write leaves the bit alone.
    assign clr = wr_acc && reg_sel == lfpit_pkg::REG_CLR && avs_writedata_i[`LFPIT_EVT_BIT];

    // A wrap in the same cycle as a clear keeps the bit set.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_ff <= 1'b0;
        end else begin
            stat_ff <= (stat_ff && !clr) || bus.wrap;
        end
    end

    // Enable bit; its writes need byte lane zero like every other register.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ien_ff <= 1'b0;
        end else if (wr_acc && reg_sel == lfpit_pkg::REG_IEN) begin
            ien_ff <= avs_writedata_i[`LFPIT_EVT_BIT];
        end
    end

    // The level interrupt follows the sticky bit while enabled; the request pin is the raw pulse.
    assign irq_o                        = stat_ff && ien_ff;
    assign interval_interrupt_request_o = bus.wrap;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------

    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // A write that starts the timer from the stopped state.
    sequence ctrl_start_s;
        ctrl_wr && !run_ff && !halt && avs_writedata_i[`LFPIT_RUN_BIT];
    endsequence

    // A write that stops a running timer.
    sequence ctrl_stop_s;
        ctrl_wr && run_ff && !avs_writedata_i[`LFPIT_RUN_BIT];
    endsequence

    // A control write that meets a missing supply bit.
    sequence ctrl_refused_s;
        wr_acc && reg_sel == lfpit_pkg::REG_CTRL && !supply && !halt;
    endsequence

    // A clear that meets no wrap in the same cycle.
    sequence clr_only_s;
        clr && !bus.wrap;
    endsequence

    // A clear and a wrap that land together.
    sequence clr_and_wrap_s;
        clr && bus.wrap;
    endsequence

    run_write_a: assert property (ctrl_wr && !halt |=> run_ff == $past(avs_writedata_i[0]))
        else $error("Run bit did not follow the control write.");
    sel_hold_a: assert property (run_ff |=> $stable(sel_ff))
        else $error("Interval code changed while running.");
    sel_start_a: assert property (ctrl_start_s |=> run_ff && sel_ff == $past(wsel))
        else $error("Starting write did not take the new code.");
    sel_stop_a: assert property (ctrl_stop_s |=> sel_ff == $past(sel_ff))
        else $error("Stopping write changed the interval code.");
    halt_clear_a: assert property (halt |=> !run_ff)
        else $error("Halt did not stop the timer.");
    halt_keep_a: assert property (halt && run_ff |=> $stable(sel_ff))
        else $error("Halt changed the interval code.");
    gate_freeze_a: assert property (!supply |=> $stable(bus.count))
        else $error("Counter moved without clock supply.");
    stop_clear_a: assert property (ctrl_stop_s and !halt |=> ##1 bus.count == '0)
        else $error("Counter not zero after stopping.");
    stat_set_a: assert property (bus.wrap |=> stat_ff ##0 irq_o == ien_ff)
        else $error("Wrap did not set the status bit.");
    wait_one_a: assert property (req && !ack_ff |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("Bus access not answered in one wait cycle.");

    // Control and start checks.
    ctrl_gate_a: assert property (ctrl_refused_s |=> $stable(run_ff) && $stable(sel_ff))
        else $error("Control write took effect without clock supply.");
    start_zero_a: assert property (ctrl_start_s |=> bus.count == '0)
        else $error("Counter did not start from zero.");

    // Status bit checks; a wrap wins over a clear in the same cycle.
    stat_hold_a: assert property (stat_ff && !clr |=> stat_ff)
        else $error("Status bit lost without a clear.");
    set_win_a: assert property (clr_and_wrap_s |=> stat_ff)
        else $error("Clear beat a wrap in the same cycle.");
    stat_clear_a: assert property (clr_only_s |=> !stat_ff)
        else $error("Status bit survived a clear.");

    // Bus checks; read data must stand at the accept edge.
    be_refuse_a: assert property (avs_write_i && !avs_byteenable_i[0]
        |=> $stable(power_ff) && $stable(ien_ff))
        else $error("Write without byte lane zero took effect.");
    read_stand_a: assert property (avs_read_i && ack_ff |-> avs_readdata_o == $past(rdata))
        else $error("Read data did not stand at the accept edge.");
    ack_one_a: assert property (ack_ff |=> !ack_ff)
        else $error("Accept lasted more than one cycle.");
    idle_wait_a: assert property (!req |-> !avs_waitrequest_o)
        else $error("Wait request raised without a request.");

    // Register writes land at the accept edge.
    power_land_a: assert property (wr_acc && reg_sel == lfpit_pkg::REG_POWER
        |=> power_ff == $past(avs_writedata_i[7:0]))
        else $error("Power register write did not land.");
    ien_land_a: assert property (wr_acc && reg_sel == lfpit_pkg::REG_IEN
        |=> ien_ff == $past(avs_writedata_i[`LFPIT_EVT_BIT]))
        else $error("Enable register write did not land.");

endmodule

// ### verification/test_low_freq_periodic_interval_timer.sv
// Self-checking testbench of the low-frequency periodic interval timer.
`include "lfpit_map.svh"

module test_low_freq_periodic_interval_timer;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                     clk_i = 1'b0;
    logic                     rst_i = 1'b1;
    logic [`LFPIT_ADDR_W-1:0] avs_address_i = '0;
    logic                     avs_read_i = 1'b0;
    logic                     avs_write_i = 1'b0;
    logic [`LFPIT_DATA_W-1:0] avs_writedata_i = '0;
    logic [`LFPIT_BE_W-1:0]   avs_byteenable_i = 4'hf;
    logic [`LFPIT_DATA_W-1:0] avs_readdata_o;
    logic                     avs_waitrequest_o;
    logic                     lf_clk = 1'b0;
    logic                     osc_en = 1'b1;
    logic                     stop_mode = 1'b0;
    logic                     sleep_mode = 1'b0;
    logic                     interval_interrupt_request_o;
    logic                     irq_o;
    logic                     prev_req = 1'b0;
    int                       failures = 0;
    int                       n_tests = 0;
    int                       pulses = 0;
    int                       seed = 14090;

    // The clock toggles every 4 ns, a period of 8 ns.
    always #4 clk_i = ~clk_i;

    low_freq_periodic_interval_timer DUT (
        .clk_i                        (clk_i),
        .rst_i                        (rst_i),
        .avs_address_i                (avs_address_i),
        .avs_read_i                   (avs_read_i),
        .avs_write_i                  (avs_write_i),
        .avs_writedata_i              (avs_writedata_i),
        .avs_byteenable_i             (avs_byteenable_i),
        .avs_readdata_o               (avs_readdata_o),
        .avs_waitrequest_o            (avs_waitrequest_o),
        .low_frequency_clock_i        (lf_clk),
        .low_freq_osc_enable_i        (osc_en),
        .stop_mode_i                  (stop_mode),
        .deepest_sleep_mode_i         (sleep_mode),
        .interval_interrupt_request_o (interval_interrupt_request_o),
        .irq_o                        (irq_o)
    );

    // ------------------------------------------------------------
    // Checks and bus tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One transfer; the request stands until waitrequest is seen low at an edge.
    task automatic bus_xfer(input logic [11:0] idx, input logic wr, input logic [7:0] d,
                            input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_i);
        avs_address_i    <= {idx, 2'b00};
        avs_write_i      <= wr;
        avs_read_i       <= ~wr;
        avs_writedata_i  <= {24'h0, d};
        avs_byteenable_i <= be;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    task automatic bus_wr(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus_xfer(idx, 1'b1, d, 4'hf, q);
    endtask

    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus_xfer(idx, 1'b0, 8'h00, 4'hf, q);
        chk(q, exp);
    endtask

    // Each tick is six system cycles, well under a quarter of the clock rate.
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_i);
            lf_clk <= 1'b1;
            repeat (3) @(posedge clk_i);
            lf_clk <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
        repeat (5) @(posedge clk_i);
    endtask

    function automatic logic [7:0] ctrl_val(input logic [2:0] code, input logic run);
        return {4'h0, code, run};
    endfunction

    // Counts request pulses and flags any pulse longer than one cycle.
    always @(posedge clk_i) begin
        if (interval_interrupt_request_o === 1'b1) begin
            pulses <= pulses + 1;
            if (prev_req === 1'b1) begin
                failures++;
                $display("[ERR] t=%0t got %h expected %h", $time, 1'b1, 1'b0);
            end
        end
        prev_req <= interval_interrupt_request_o;
    end

    // A hang is cut short well after the longest expected run of about 50k cycles.
    initial begin
        repeat (90000) @(posedge clk_i);
        failures++;
        $display("[ERR] t=%0t got %h expected %h", $time, 1'b0, 1'b1);
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [2:0]  r;
        logic        en;
        int          n;
        logic [31:0] q;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(`LFPIT_IDX_POWER, 32'h0);
        rd_chk(`LFPIT_IDX_CTRL, 32'h0);
        bus_wr(`LFPIT_IDX_CTRL, 8'h0f);
        rd_chk(`LFPIT_IDX_CTRL, 32'h0);
        rd_chk(12'h000, 32'h0);
        bus_wr(`LFPIT_IDX_POWER, 8'h20);
        rd_chk(`LFPIT_IDX_POWER, 32'h20);
        bus_xfer(`LFPIT_IDX_IEN, 1'b1, 8'h01, 4'h0, q);
        rd_chk(`LFPIT_IDX_IEN, 32'h0);
        bus_wr(`LFPIT_IDX_CLR, 8'h01);
        rd_chk(`LFPIT_IDX_CLR, 32'h0);
        $display("test registers done");
        // Random codes are stored while stopped.
        repeat (4) begin
            r = 3'($random(seed));
            bus_wr(`LFPIT_IDX_CTRL, ctrl_val(r, 1'b0));
            rd_chk(`LFPIT_IDX_CTRL, {24'h0, ctrl_val(r, 1'b0)});
        end
        $display("test code store done");
        // Supply stays set up to the mid-run reset, so no run ever loses its clock supply.
        // Longest intervals would take too long here; codes 7 down to 3 are run.
        for (int c = 7; c >= 3; c--) begin
            en = 1'($random(seed));
            n = 1 << (15 - c);
            bus_wr(`LFPIT_IDX_IEN, {7'h0, en});
            bus_wr(`LFPIT_IDX_CTRL, ctrl_val(3'(c), 1'b1));
            pulses = 0;
            ticks(n - 1);
            rd_chk(`LFPIT_IDX_CNT, 32'(n - 1));
            chk(32'(pulses), 32'h0);
            ticks(1);
            chk(32'(pulses), 32'h1);
            rd_chk(`LFPIT_IDX_STAT, 32'h1);
            chk({31'h0, irq_o}, {31'h0, en});
            if (c == 7) begin
                ticks(n);
                chk(32'(pulses), 32'h2);
            end
            bus_wr(`LFPIT_IDX_CTRL, ctrl_val(3'(c) ^ 3'h5, 1'b1));
            rd_chk(`LFPIT_IDX_CTRL, {24'h0, ctrl_val(3'(c), 1'b1)});
            bus_wr(`LFPIT_IDX_CTRL, ctrl_val(3'(c) ^ 3'h2, 1'b0));
            rd_chk(`LFPIT_IDX_CTRL, {24'h0, ctrl_val(3'(c), 1'b0)});
            rd_chk(`LFPIT_IDX_CNT, 32'h0);
            bus_wr(`LFPIT_IDX_CLR, 8'h01);
            rd_chk(`LFPIT_IDX_STAT, 32'h0);
            chk({31'h0, irq_o}, 32'h0);
            $display("test interval code %0d done", c);
        end
        // Each halt source stops the timer and keeps the code.
        for (int h = 0; h < 3; h++) begin
            bus_wr(`LFPIT_IDX_CTRL, ctrl_val(3'h6, 1'b1));
            ticks(3);
            osc_en     <= (h != 0);
            stop_mode  <= (h == 1);
            sleep_mode <= (h == 2);
            repeat (4) @(posedge clk_i);
            osc_en     <= 1'b1;
            stop_mode  <= 1'b0;
            sleep_mode <= 1'b0;
            repeat (4) @(posedge clk_i);
            rd_chk(`LFPIT_IDX_CTRL, {24'h0, ctrl_val(3'h6, 1'b0)});
            rd_chk(`LFPIT_IDX_CNT, 32'h0);
            $display("test halt source %0d done", h);
        end
        // A reset in mid-run stops the timer and clears the power register.
        bus_wr(`LFPIT_IDX_CTRL, ctrl_val(3'h7, 1'b1));
        ticks(2);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(`LFPIT_IDX_CTRL, 32'h0);
        rd_chk(`LFPIT_IDX_CNT, 32'h0);
        rd_chk(`LFPIT_IDX_POWER, 32'h0);
        $display("test mid-run reset done");
        give_verdict();
    end

endmodule
